// file: verilog/rss_pkg.sv
// Constants shared by the rotate, subtract and skip execution block.
// Assumes a 32-bit AXI4-Lite register bus and one 20 MHz core clock.
package rss_pkg;
	// Register byte offsets
	localparam logic [7:0] OFF_CMD    = 8'h00;
	localparam logic [7:0] OFF_WORK   = 8'h04;
	localparam logic [7:0] OFF_FLAGS  = 8'h08;
	localparam logic [7:0] OFF_MADDR  = 8'h0C;
	localparam logic [7:0] OFF_MDATA  = 8'h10;
	localparam logic [7:0] OFF_STATUS = 8'h14;
	// Register selector codes
	localparam logic [2:0] SEL_CMD    = 3'h0;
	localparam logic [2:0] SEL_WORK   = 3'h1;
	localparam logic [2:0] SEL_FLAGS  = 3'h2;
	localparam logic [2:0] SEL_MADDR  = 3'h3;
	localparam logic [2:0] SEL_MDATA  = 3'h4;
	localparam logic [2:0] SEL_STATUS = 3'h5;
	localparam logic [2:0] SEL_NONE   = 3'h7;
	// Field positions
	localparam int FLAG_BORROW  = 0;
	localparam int FLAG_NIBBLE  = 1;
	localparam int FLAG_NULL    = 2;
	localparam int FLAG_EXCESS  = 3;
	localparam int STAT_BUSY    = 0;
	localparam int STAT_SKIP    = 1;
	localparam int STAT_CNT_LSB = 8;
	localparam int CMD_ADDR_LSB = 8;
	// Instruction codes
	localparam logic [2:0] OP_ROTATE_RIGHT_THROUGH_FLAG_TO_WORKING = 3'h0;
	localparam logic [2:0] OP_SUBTRACT_WITH_BORROW                 = 3'h1;
	localparam logic [2:0] OP_SUBTRACT_WITH_BORROW_TO_MEMORY       = 3'h2;
	localparam logic [2:0] OP_DECREMENT_SKIP_IF_NULL               = 3'h3;
	localparam logic [2:0] OP_DECREMENT_SKIP_IF_NULL_TO_WORKING    = 3'h4;
	// Reset values and bus response codes
	localparam logic [7:0] WORK_RESET  = 8'h00;
	localparam logic [3:0] FLAGS_RESET = 4'h0;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Execution states
	typedef enum logic [1:0] {
		RSS_IDLE  = 2'b00,
		RSS_EXEC  = 2'b01,
		RSS_DUMMY = 2'b10
	} rss_state_e;
endpackage

// file: verilog/rss_alu.sv
// Combinational datapath for the rotate, subtract and skip instructions.
// Assumes operands are stable for the whole execute cycle.
module rss_alu (
	input  wire logic [2:0] op,
	input  wire logic [7:0] work,
	input  wire logic [7:0] operand,
	input  wire logic       borrow_in,
	output logic      [7:0] result,
	output logic            borrow_out,
	output logic            nibble_out,
	output logic            excess_out,
	output logic            null_out,
	output logic            wr_work,
	output logic            wr_mem,
	output logic            upd_arith,
	output logic            upd_borrow,
	output logic            two_cycle,
	output logic            skip
);
	logic [8:0] diff;
	logic [4:0] ndiff;
	logic [7:0] dec;
	logic       is_rot;
	logic       is_sub;
	logic       is_dec;

	// Opcode classes
	assign is_rot = op == rss_pkg::OP_ROTATE_RIGHT_THROUGH_FLAG_TO_WORKING;
	assign is_sub = op == rss_pkg::OP_SUBTRACT_WITH_BORROW
		|| op == rss_pkg::OP_SUBTRACT_WITH_BORROW_TO_MEMORY;
	assign is_dec = op == rss_pkg::OP_DECREMENT_SKIP_IF_NULL
		|| op == rss_pkg::OP_DECREMENT_SKIP_IF_NULL_TO_WORKING;

	// Subtract, borrow-in is the inverse of the carry
	assign diff  = {1'b0, work} - {1'b0, operand} - {8'h00, !borrow_in};
	assign ndiff = {1'b0, work[3:0]} - {1'b0, operand[3:0]}
		- {4'h0, !borrow_in};
	assign dec   = operand - 8'h01;

	// Result and flags
	assign result     = is_rot ? {borrow_in, operand[7:1]}
		: (is_sub ? diff[7:0] : dec);
	assign borrow_out = is_rot ? operand[0] : !diff[8];
	assign nibble_out = !ndiff[4];
	assign null_out   = diff[7:0] == 8'h00;
	assign excess_out = (work[7] != operand[7]) && (diff[7] != work[7]);

	// Destinations and side effects
	assign wr_work    = is_rot || op == rss_pkg::OP_SUBTRACT_WITH_BORROW
		|| op == rss_pkg::OP_DECREMENT_SKIP_IF_NULL_TO_WORKING;
	assign wr_mem     = op == rss_pkg::OP_SUBTRACT_WITH_BORROW_TO_MEMORY
		|| op == rss_pkg::OP_DECREMENT_SKIP_IF_NULL;
	assign upd_arith  = is_sub;
	assign upd_borrow = is_rot || is_sub;
	assign two_cycle  = is_dec;
	assign skip       = is_dec && dec == 8'h00;
endmodule

// file: verilog/rss_core.sv
// Execution block for rotate-through-carry, subtract-with-borrow and
// decrement-and-skip, with its working register, flags and data memory.
// Assumes an AXI4-Lite master on core_clk and a synchronous reset.
//
// Notes on behaviour
// - rotate right, old carry into bit seven
// - rotate writes working register, only carry changes
// - subtract operand and inverse carry from working
// - carry clear on negative, set otherwise
// - memory form subtracts alike, writes memory
// - decrement memory, skip next when zero
// - decrement-and-skip takes two cycles
// - working form: operand minus one into working
//
// The AXI4-Lite interface to the registers and the register offsets were chosen for this implementation.
module rss_core #(
	parameter int MEM_AW = 4
) (
	input  wire logic        core_clk,
	input  wire logic        reset,
	input  wire logic        clk_en,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             busy,
	output logic             skip_next
);
	localparam int DEPTH = 1 << MEM_AW;
	localparam int CMD_ADDR_MSB = rss_pkg::CMD_ADDR_LSB + MEM_AW - 1;

	rss_pkg::rss_state_e state_reg;
	rss_pkg::rss_state_e state_next;
	logic [7:0]        mem [DEPTH];
	logic [2:0]        cmd_op_reg;
	logic [MEM_AW-1:0] cmd_addr_reg;
	logic [MEM_AW-1:0] maddr_reg;
	logic [7:0]        working_register_reg;
	logic              borrow_inverse_bit_reg;
	logic              nibble_borrow_bit_reg;
	logic              result_null_flag_reg;
	logic              signed_excess_flag_reg;
	logic              skip_reg;
	logic [7:0]        skip_cnt_reg;
	logic              aw_held_reg;
	logic [7:0]        aw_addr_reg;
	logic              w_held_reg;
	logic [31:0]       w_data_reg;
	logic [3:0]        w_strb_reg;
	logic              bvalid_reg;
	logic [1:0]        bresp_reg;
	logic              rvalid_reg;
	logic [31:0]       rdata_reg;
	logic [1:0]        rresp_reg;

	// Register selector, shared by write and read decode
	function automatic logic [2:0] rss_sel(input logic [7:0] addr);
		if (addr == rss_pkg::OFF_CMD)
			return rss_pkg::SEL_CMD;
		else if (addr == rss_pkg::OFF_WORK)
			return rss_pkg::SEL_WORK;
		else if (addr == rss_pkg::OFF_FLAGS)
			return rss_pkg::SEL_FLAGS;
		else if (addr == rss_pkg::OFF_MADDR)
			return rss_pkg::SEL_MADDR;
		else if (addr == rss_pkg::OFF_MDATA)
			return rss_pkg::SEL_MDATA;
		else if (addr == rss_pkg::OFF_STATUS)
			return rss_pkg::SEL_STATUS;
		else
			return rss_pkg::SEL_NONE;
	endfunction

	// Datapath hookup
	logic [7:0] cur_operand;
	logic [7:0] alu_result;
	logic       alu_borrow;
	logic       alu_nibble;
	logic       alu_excess;
	logic       alu_null;
	logic       alu_wr_work;
	logic       alu_wr_mem;
	logic       alu_upd_arith;
	logic       alu_upd_borrow;
	logic       alu_two_cycle;
	logic       alu_skip;
	logic       exec_fire;
	logic [3:0] flags_vec;

	assign cur_operand = mem[cmd_addr_reg];
	assign exec_fire   = clk_en && state_reg == rss_pkg::RSS_EXEC;
	assign flags_vec   = {signed_excess_flag_reg, result_null_flag_reg,
		nibble_borrow_bit_reg, borrow_inverse_bit_reg};

	rss_alu u_alu (
		.op         (cmd_op_reg),
		.work       (working_register_reg),
		.operand    (cur_operand),
		.borrow_in  (borrow_inverse_bit_reg),
		.result     (alu_result),
		.borrow_out (alu_borrow),
		.nibble_out (alu_nibble),
		.excess_out (alu_excess),
		.null_out   (alu_null),
		.wr_work    (alu_wr_work),
		.wr_mem     (alu_wr_mem),
		.upd_arith  (alu_upd_arith),
		.upd_borrow (alu_upd_borrow),
		.two_cycle  (alu_two_cycle),
		.skip       (alu_skip)
	);

	// Bus handshakes, all gated by the clock enable
	logic       aw_fire;
	logic       w_fire;
	logic       ar_fire;
	logic       do_write;
	logic [2:0] wr_sel;
	logic [2:0] rd_sel;
	logic [31:0] rd_data;
	logic       start_cmd;

	assign s_axi_awready = clk_en && !aw_held_reg && !bvalid_reg;
	assign s_axi_wready  = clk_en && !w_held_reg && !bvalid_reg;
	assign s_axi_arready = clk_en && !rvalid_reg;
	assign aw_fire  = s_axi_awvalid && s_axi_awready;
	assign w_fire   = s_axi_wvalid && s_axi_wready;
	assign ar_fire  = s_axi_arvalid && s_axi_arready;
	assign do_write = clk_en && aw_held_reg && w_held_reg && !bvalid_reg
		&& state_reg == rss_pkg::RSS_IDLE;
	assign wr_sel   = rss_sel(aw_addr_reg);
	assign rd_sel   = rss_sel(s_axi_araddr);
	assign start_cmd = do_write && wr_sel == rss_pkg::SEL_CMD && w_strb_reg[0];

	// Read data multiplexer
	assign rd_data =
		rd_sel == rss_pkg::SEL_CMD ? {{(24 - MEM_AW){1'b0}},
			cmd_addr_reg, 5'h00, cmd_op_reg} :
		rd_sel == rss_pkg::SEL_WORK ? {24'h000000, working_register_reg} :
		rd_sel == rss_pkg::SEL_FLAGS ? {28'h0000000, flags_vec} :
		rd_sel == rss_pkg::SEL_MADDR ? {{(32 - MEM_AW){1'b0}}, maddr_reg} :
		rd_sel == rss_pkg::SEL_MDATA ? {24'h000000, mem[maddr_reg]} :
		rd_sel == rss_pkg::SEL_STATUS ? {16'h0000, skip_cnt_reg, 6'h00,
			skip_reg, busy} : 32'h00000000;

	// Write address and data holding
	always_ff @(posedge core_clk) begin
		if (reset) begin
			aw_held_reg <= 1'b0;
			w_held_reg  <= 1'b0;
		end else if (clk_en) begin
			aw_held_reg <= aw_fire || (aw_held_reg && !do_write);
			w_held_reg  <= w_fire || (w_held_reg && !do_write);
		end
	end

	always_ff @(posedge core_clk) begin
		if (aw_fire)
			aw_addr_reg <= s_axi_awaddr;
		if (w_fire) begin
			w_data_reg <= s_axi_wdata;
			w_strb_reg <= s_axi_wstrb;
		end
	end

	// Write and read responses
	always_ff @(posedge core_clk) begin
		if (reset) begin
			bvalid_reg <= 1'b0;
			bresp_reg  <= rss_pkg::RESP_OKAY;
			rvalid_reg <= 1'b0;
			rresp_reg  <= rss_pkg::RESP_OKAY;
			rdata_reg  <= 32'h00000000;
		end else if (clk_en) begin
			if (do_write) begin
				bvalid_reg <= 1'b1;
				bresp_reg  <= wr_sel == rss_pkg::SEL_NONE ?
					rss_pkg::RESP_SLVERR : rss_pkg::RESP_OKAY;
			end else if (s_axi_bready)
				bvalid_reg <= 1'b0;
			if (ar_fire) begin
				rvalid_reg <= 1'b1;
				rdata_reg  <= rd_data;
				rresp_reg  <= rd_sel == rss_pkg::SEL_NONE ?
					rss_pkg::RESP_SLVERR : rss_pkg::RESP_OKAY;
			end else if (s_axi_rready)
				rvalid_reg <= 1'b0;
		end
	end

	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp  = bresp_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata  = rdata_reg;
	assign s_axi_rresp  = rresp_reg;

	// Sequencer: idle, execute, then a dummy slot for skip instructions
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			rss_pkg::RSS_IDLE:
				if (start_cmd)
					state_next = rss_pkg::RSS_EXEC;
			rss_pkg::RSS_EXEC:
				state_next = alu_two_cycle ? rss_pkg::RSS_DUMMY
					: rss_pkg::RSS_IDLE;
			default:
				state_next = rss_pkg::RSS_IDLE;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (reset)
			state_reg <= rss_pkg::RSS_IDLE;
		else if (clk_en)
			state_reg <= state_next;
	end

	assign busy      = state_reg != rss_pkg::RSS_IDLE;
	assign skip_next = skip_reg;

	// Command, pointer and skip bookkeeping
	always_ff @(posedge core_clk) begin
		if (reset) begin
			cmd_op_reg   <= 3'h0;
			cmd_addr_reg <= '0;
			maddr_reg    <= '0;
			skip_reg     <= 1'b0;
			skip_cnt_reg <= 8'h00;
		end else if (clk_en) begin
			if (start_cmd) begin
				cmd_op_reg <= w_data_reg[2:0];
				if (w_strb_reg[1])
					cmd_addr_reg <= w_data_reg[CMD_ADDR_MSB:
						rss_pkg::CMD_ADDR_LSB];
			end
			if (do_write && wr_sel == rss_pkg::SEL_MADDR && w_strb_reg[0])
				maddr_reg <= w_data_reg[MEM_AW-1:0];
			skip_reg <= exec_fire && alu_skip;
			if (exec_fire && alu_skip)
				skip_cnt_reg <= skip_cnt_reg + 8'h01;
		end
	end

	// Working register and flags: bus writes or instruction results
	always_ff @(posedge core_clk) begin
		if (reset) begin
			working_register_reg <= rss_pkg::WORK_RESET;
			{signed_excess_flag_reg, result_null_flag_reg,
				nibble_borrow_bit_reg, borrow_inverse_bit_reg}
				<= rss_pkg::FLAGS_RESET;
		end else if (clk_en) begin
			if (do_write && w_strb_reg[0]) begin
				if (wr_sel == rss_pkg::SEL_WORK)
					working_register_reg <= w_data_reg[7:0];
				if (wr_sel == rss_pkg::SEL_FLAGS)
					{signed_excess_flag_reg, result_null_flag_reg,
						nibble_borrow_bit_reg, borrow_inverse_bit_reg}
						<= w_data_reg[3:0];
			end
			if (exec_fire && alu_wr_work)
				working_register_reg <= alu_result;
			if (exec_fire && alu_upd_borrow)
				borrow_inverse_bit_reg <= alu_borrow;
			if (exec_fire && alu_upd_arith) begin
				nibble_borrow_bit_reg  <= alu_nibble;
				result_null_flag_reg   <= alu_null;
				signed_excess_flag_reg <= alu_excess;
			end
		end
	end

	// Data memory
	always_ff @(posedge core_clk) begin
		if (clk_en) begin
			if (do_write && wr_sel == rss_pkg::SEL_MDATA && w_strb_reg[0])
				mem[maddr_reg] <= w_data_reg[7:0];
			if (exec_fire && alu_wr_mem)
				mem[cmd_addr_reg] <= alu_result;
		end
	end

	// Checks on instruction results
	logic [6:0] opd_upper;
	logic       opd_lsb;
	logic       is_rot_cmd;
	logic       is_dec_cmd;
	assign opd_upper  = cur_operand[7:1];
	assign opd_lsb    = cur_operand[0];
	assign is_rot_cmd = cmd_op_reg
		== rss_pkg::OP_ROTATE_RIGHT_THROUGH_FLAG_TO_WORKING;
	assign is_dec_cmd = alu_two_cycle;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (reset);

	a_rotate_bits: assert property (exec_fire && is_rot_cmd |=>
		working_register_reg == {$past(borrow_inverse_bit_reg),
		$past(opd_upper)} && borrow_inverse_bit_reg == $past(opd_lsb))
		else $error("rotate result or carry wrong");
	a_rotate_side: assert property (exec_fire && is_rot_cmd |=>
		$stable(cur_operand) && $stable(flags_vec[3:1]))
		else $error("rotate touched memory or other flags");
	a_sub_result: assert property (exec_fire && cmd_op_reg
		== rss_pkg::OP_SUBTRACT_WITH_BORROW |=> working_register_reg
		== $past(working_register_reg) - $past(cur_operand)
		- {7'h00, !$past(borrow_inverse_bit_reg)}
		&& result_null_flag_reg == (working_register_reg == 8'h00))
		else $error("subtract result or null flag wrong");
	a_sub_carry: assert property (exec_fire && alu_upd_arith |=>
		borrow_inverse_bit_reg == ({1'b0, $past(working_register_reg)}
		>= {1'b0, $past(cur_operand)}
		+ {8'h00, !$past(borrow_inverse_bit_reg)}))
		else $error("subtract carry wrong");
	a_sub_memory: assert property (exec_fire && cmd_op_reg
		== rss_pkg::OP_SUBTRACT_WITH_BORROW_TO_MEMORY |=>
		cur_operand == $past(alu_result) && $stable(working_register_reg))
		else $error("memory subtract wrong destination");
	a_dec_memory: assert property (exec_fire && cmd_op_reg
		== rss_pkg::OP_DECREMENT_SKIP_IF_NULL |=>
		cur_operand == $past(cur_operand) - 8'h01
		&& skip_next == (cur_operand == 8'h00))
		else $error("decrement to memory or skip wrong");
	a_dec_two_cycle: assert property (exec_fire |=>
		(state_reg == rss_pkg::RSS_DUMMY) == $past(is_dec_cmd)
		&& busy == $past(is_dec_cmd))
		else $error("instruction length wrong");
	a_dec_working: assert property (exec_fire && cmd_op_reg
		== rss_pkg::OP_DECREMENT_SKIP_IF_NULL_TO_WORKING |=>
		working_register_reg == $past(cur_operand) - 8'h01
		&& $stable(cur_operand)
		&& skip_next == (working_register_reg == 8'h00))
		else $error("decrement to working wrong");
	a_dec_flags: assert property (exec_fire && is_dec_cmd |=>
		$stable(flags_vec)) else $error("decrement changed a flag");

	c_rotate: cover property (exec_fire && is_rot_cmd);
	c_skip_taken: cover property (skip_next);
	c_sub_negative: cover property (exec_fire && alu_upd_arith && !alu_borrow);
	c_bad_address: cover property (do_write && wr_sel == rss_pkg::SEL_NONE);
endmodule

// file: tb/rss_core_tb.sv
// Self-checking bench for the rotate, subtract and skip execution block.
// Assumes rss_pkg and rss_core are compiled first; one 20 MHz clock.
module rss_core_tb;
	timeunit 1ns;
	timeprecision 1ns;

	logic        core_clk;
	logic        reset;
	logic        clk_en;
	logic [7:0]  s_axi_awaddr;
	logic        s_axi_awvalid;
	logic        s_axi_awready;
	logic [31:0] s_axi_wdata;
	logic [3:0]  s_axi_wstrb;
	logic        s_axi_wvalid;
	logic        s_axi_wready;
	logic [1:0]  s_axi_bresp;
	logic        s_axi_bvalid;
	logic        s_axi_bready;
	logic [7:0]  s_axi_araddr;
	logic        s_axi_arvalid;
	logic        s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0]  s_axi_rresp;
	logic        s_axi_rvalid;
	logic        s_axi_rready;
	logic        busy;
	logic        skip_next;
	int          fail_count;
	int          n_compared;
	logic        b_busy;
	logic [2:0]  cop [8] = '{3'h3, 3'h4, 3'h3, 3'h4, 3'h1, 3'h1, 3'h2, 3'h0};
	logic [7:0]  cm [8]  = '{8'h01, 8'h01, 8'h00, 8'h00,
	                         8'h55, 8'h80, 8'hFF, 8'h01};
	logic [7:0]  cw [8]  = '{8'h00, 8'h00, 8'h00, 8'h00,
	                         8'h55, 8'h7F, 8'h00, 8'h00};
	logic [3:0]  cf [8]  = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h1, 4'h1, 4'h0, 4'h1};

	rss_core #(
		.MEM_AW(4)
	) DUT (
		.core_clk      (core_clk),
		.reset         (reset),
		.clk_en        (clk_en),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.busy          (busy),
		.skip_next     (skip_next)
	);

	// Free-running 50 ns clock
	always #25 core_clk = ~core_clk;

	// Verdict and end of run
	task automatic end_of_test();
		if (fail_count == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Compare with four-state equality
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
			fail_count++;
		end
	endtask

	// Pseudo-random source, seeded with 25
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	// Expected effect of one instruction on working, memory and flags
	function automatic void model(input logic [2:0] op,
		inout logic [7:0] w, inout logic [7:0] m, inout logic [3:0] f,
		output logic sk);
		logic [8:0] d9;
		logic [4:0] d5;
		logic       ex;
		sk = 1'b0;
		d9 = {1'b0, w} - {1'b0, m} - {8'h00, !f[0]};
		d5 = {1'b0, w[3:0]} - {1'b0, m[3:0]} - {4'h0, !f[0]};
		ex = (w[7] != m[7]) && (d9[7] != w[7]);
		case (op)
			rss_pkg::OP_ROTATE_RIGHT_THROUGH_FLAG_TO_WORKING: begin
				w = {f[0], m[7:1]};
				f[0] = m[0];
			end
			rss_pkg::OP_SUBTRACT_WITH_BORROW: begin
				f = {ex, d9[7:0] == 8'h00, !d5[4], !d9[8]};
				w = d9[7:0];
			end
			rss_pkg::OP_SUBTRACT_WITH_BORROW_TO_MEMORY: begin
				f = {ex, d9[7:0] == 8'h00, !d5[4], !d9[8]};
				m = d9[7:0];
			end
			rss_pkg::OP_DECREMENT_SKIP_IF_NULL: begin
				m = m - 8'h01;
				sk = (m == 8'h00);
			end
			rss_pkg::OP_DECREMENT_SKIP_IF_NULL_TO_WORKING: begin
				w = m - 8'h01;
				sk = (w == 8'h00);
			end
			default: ;
		endcase
	endfunction

	// AXI4-Lite write, address and data offered together
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		int   i;
		logic ad;
		logic wd;
		logic dn;
		@(posedge core_clk);
		ad = 1'b0;
		wd = 1'b0;
		dn = 1'b0;
		r = 2'h3;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (i = 0; i < 40 && !dn; i++) begin
			@(posedge core_clk);
			if (ad && wd && s_axi_bvalid === 1'b1) begin
				r = s_axi_bresp;
				b_busy = busy;
				s_axi_bready <= 1'b0;
				dn = 1'b1;
			end
			if (!ad && s_axi_awready === 1'b1) begin
				ad = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!wd && s_axi_wready === 1'b1) begin
				wd = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		if (!dn) begin
			fail_count++;
			end_of_test();
		end
	endtask

	// AXI4-Lite read
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		int   i;
		logic ar;
		logic dn;
		@(posedge core_clk);
		ar = 1'b0;
		dn = 1'b0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (i = 0; i < 40 && !dn; i++) begin
			@(posedge core_clk);
			if (ar && s_axi_rvalid === 1'b1) begin
				d = s_axi_rdata;
				r = s_axi_rresp;
				s_axi_rready <= 1'b0;
				dn = 1'b1;
			end
			if (!ar && s_axi_arready === 1'b1) begin
				ar = 1'b1;
				s_axi_arvalid <= 1'b0;
			end
		end
		if (!dn) begin
			fail_count++;
			end_of_test();
		end
	endtask

	// Issue one instruction, count busy cycles and catch the skip pulse
	task automatic run_cmd(input logic [2:0] op, input logic [3:0] ad,
		output int n, output logic sk);
		int         i;
		logic [1:0] r;
		axi_wr(rss_pkg::OFF_CMD, {20'h0, ad, 5'h0, op}, r);
		chk("cmd_resp", 32'(rss_pkg::RESP_OKAY), 32'(r));
		n = (b_busy === 1'b1) ? 1 : 0;
		sk = 1'b0;
		for (i = 0; i < 10; i++) begin
			@(posedge core_clk);
			if (skip_next === 1'b1) sk = 1'b1;
			if (busy !== 1'b1) break;
			n++;
		end
		// Busy never dropped: count it and stop
		if (busy === 1'b1) begin
			fail_count++;
			end_of_test();
		end
	endtask

	// Reset, register checks, then corner and random instructions
	initial begin
		logic [15:0] st;
		logic [31:0] d;
		logic [1:0]  r;
		logic [2:0]  op;
		logic [7:0]  w;
		logic [7:0]  m;
		logic [3:0]  f;
		logic [3:0]  ad;
		logic [7:0]  scnt;
		logic        sk;
		logic        esk;
		int          n;
		core_clk = 1'b0;
		reset = 1'b1;
		clk_en = 1'b1;
		s_axi_awaddr = 8'h00;
		s_axi_awvalid = 1'b0;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'h3;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b0;
		s_axi_araddr = 8'h00;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
		fail_count = 0;
		n_compared = 0;
		st = 16'h0019;
		scnt = 8'h00;
		repeat (3) @(posedge core_clk);
		reset <= 1'b0;
		axi_rd(rss_pkg::OFF_WORK, d, r);
		chk("work_reset", 32'(rss_pkg::WORK_RESET), d);
		axi_rd(rss_pkg::OFF_FLAGS, d, r);
		chk("flags_reset", 32'(rss_pkg::FLAGS_RESET), d);
		axi_wr(8'h20, 32'hFF, r);
		chk("unmapped_wresp", 32'(rss_pkg::RESP_SLVERR), 32'(r));
		axi_rd(8'h20, d, r);
		chk("unmapped_rresp", 32'(rss_pkg::RESP_SLVERR), 32'(r));
		chk("unmapped_rdata", 32'h0, d);
		for (int it = 0; it < 160; it++) begin
			st = lfsr_next(st);
			op = 3'(st % 16'h0006);
			st = lfsr_next(st);
			w = st[7:0];
			m = st[15:8];
			st = lfsr_next(st);
			f = st[3:0];
			ad = st[7:4];
			if (it < 8) begin
				op = cop[it];
				m = cm[it];
				w = cw[it];
				f = cf[it];
			end
			axi_wr(rss_pkg::OFF_MADDR, 32'(ad), r);
			axi_wr(rss_pkg::OFF_MDATA, 32'(m), r);
			axi_wr(rss_pkg::OFF_WORK, 32'(w), r);
			axi_wr(rss_pkg::OFF_FLAGS, 32'(f), r);
			// Freeze now and then: awready must drop with the enable
			if (st[8]) begin
				clk_en <= 1'b0;
				@(posedge core_clk);
				@(posedge core_clk);
				chk("awready_frozen", 32'h0, 32'(s_axi_awready));
				clk_en <= 1'b1;
			end
			run_cmd(op, ad, n, sk);
			model(op, w, m, f, esk);
			if (esk) scnt++;
			chk("busy_cycles", (op == 3'h3 || op == 3'h4) ? 2 : 1, 32'(n));
			chk("skip_pulse", 32'(esk), 32'(sk));
			axi_rd(rss_pkg::OFF_WORK, d, r);
			chk("work", 32'(w), d);
			axi_rd(rss_pkg::OFF_FLAGS, d, r);
			chk("flags", 32'(f), d);
			axi_rd(rss_pkg::OFF_MDATA, d, r);
			chk("memory", 32'(m), d);
			axi_rd(rss_pkg::OFF_STATUS, d, r);
			chk("skip_count", 32'(scnt), 32'(d[15:8]));
		end
		end_of_test();
	end
endmodule
